// File: hrp_core.sv
// What this block does
// [R1] one shared clock for every interface signal
// [R2] bridge drives 5-bit register select
// [R3] read strobe high exactly one cycle
// [R4] write strobe high exactly one cycle
// [R5] core drives read word of addressed register
// [R6] write word captured into addressed register
// [R7] sixteen io cell inputs sampled
// [R8] sixteen io cell output data bits driven
// [R9] enable bit low drives the cell
// [R10] enable bit high leaves cell undriven
// [R11] unconfigured: all enables read inactive
// [R12] read word is a combinational address mux
// [R13] register reloads only on write and match; the read counter steps on reads of the input register
// [R14] read acknowledge is strobe and address match
// [R15] start-up values without any reset input; the core still takes rst_n_i, and the bridge state starts only from it
// [R16] read and write never share a cycle
`timescale 1ns/1ps
`default_nettype none
`include "hrp_regs.svh"
module hrp_core
    import hrp_pkg::*;
#(
    parameter int IO_W = `HRP_IO_W
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    hrp_if.core bus,
    input wire logic [IO_W-1:0] io_cell_inputs_i,
    output logic [IO_W-1:0] io_cell_outputs_o,
    output logic [IO_W-1:0] io_output_enable_n_o
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic hit(input logic [`HRP_ADDR_W-1:0] sel,
                                 input logic [`HRP_ADDR_W-1:0] idx);
        hit = (sel == idx);
    endfunction

    logic [IO_W-1:0] io_in;
    // declaration values stand for configuration; reset only re-seeds them
    logic [IO_W-1:0] out_word = IO_W'(`HRP_OUT_INIT); // R15
    logic [IO_W-1:0] oen_word = IO_W'(`HRP_OEN_INIT); // R15 R11
    logic [`HRP_DATA_W-1:0] scratch = `HRP_SCRATCH_INIT; // R15
    logic [`HRP_DATA_W-1:0] read_count = '0; // R15
    logic read_ack_in;

    // cells are off-clock, so two flops before use
    io_sync #(.WIDTH(IO_W)) u_sync ( // R7
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(io_cell_inputs_i),
        .sync_o(io_in)
    );

    ////////////////////////////////////////////////////////////////////////
    assign io_cell_outputs_o = out_word; // R8
    assign io_output_enable_n_o = oen_word; // R9

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_word <= IO_W'(`HRP_OUT_INIT);
        end else if (bus.write_strobe
                     && hit(bus.reg_select, `HRP_REG_OUT)) begin // R13 R6 R8
            out_word <= bus.reg_write_word[IO_W-1:0];
        end
    end

    // all-ones keeps every cell high-z until software enables it
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oen_word <= IO_W'(`HRP_OEN_INIT); // R11 R10
        end else if (bus.write_strobe
                     && hit(bus.reg_select, `HRP_REG_OEN)) begin // R13 R9
            oen_word <= bus.reg_write_word[IO_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scratch <= `HRP_SCRATCH_INIT;
        end else if (bus.write_strobe
                     && hit(bus.reg_select, `HRP_REG_SCRATCH)) begin // R13 R6
            scratch <= bus.reg_write_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read side effect: count reads of the input register
    assign read_ack_in = bus.read_strobe && hit(bus.reg_select, `HRP_REG_IN); // R14

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            read_count <= '0;
        end else if (read_ack_in) begin
            read_count <= read_count + 16'h0001;
        end
    end

    always_comb begin // R12 R5
        bus.reg_read_word = `HRP_UNMAPPED;
        if (hit(bus.reg_select, `HRP_REG_OUT)) begin
            bus.reg_read_word = `HRP_DATA_W'(out_word);
        end else if (hit(bus.reg_select, `HRP_REG_OEN)) begin
            bus.reg_read_word = `HRP_DATA_W'(oen_word);
        end else if (hit(bus.reg_select, `HRP_REG_IN)) begin
            bus.reg_read_word = `HRP_DATA_W'(io_in);
        end else if (hit(bus.reg_select, `HRP_REG_SCRATCH)) begin
            bus.reg_read_word = scratch;
        end else if (hit(bus.reg_select, `HRP_REG_RDCNT)) begin
            bus.reg_read_word = read_count;
        end
    end
endmodule // hrp_core
`default_nettype wire

// File: hrp_regs.svh
`ifndef HRP_REGS_SVH
`define HRP_REGS_SVH

// link reference clock; this build runs from the 50 MHz input instead
`define HRP_LINK_CLK_MHZ 30
`define HRP_ADDR_W 5
`define HRP_DATA_W 16
`define HRP_IO_W 16

// register indices on the 5-bit select
`define HRP_REG_OUT 5'h00
`define HRP_REG_OEN 5'h01
`define HRP_REG_IN 5'h02
`define HRP_REG_SCRATCH 5'h03
`define HRP_REG_RDCNT 5'h04

// start-up values and the unmapped read word
`define HRP_OUT_INIT 16'h0000
`define HRP_OEN_INIT 16'hffff
`define HRP_SCRATCH_INIT 16'h0000
`define HRP_UNMAPPED 16'ha55a

`endif

// File: hrp_pkg.sv
`default_nettype none
package hrp_pkg;
    typedef enum logic [2:0] {
        BR_IDLE = 3'b001,
        BR_READ = 3'b010,
        BR_WRITE = 3'b100
    } bridge_state_t;
endpackage
`default_nettype wire

// File: hrp_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "hrp_regs.svh"
interface hrp_if;
    logic [`HRP_ADDR_W-1:0] reg_select;
    logic read_strobe;
    logic write_strobe;
    logic [`HRP_DATA_W-1:0] reg_write_word;
    logic [`HRP_DATA_W-1:0] reg_read_word;

    modport core (
        input reg_select,
        input read_strobe,
        input write_strobe,
        input reg_write_word,
        output reg_read_word
    );
    modport bridge (
        output reg_select,
        output read_strobe,
        output write_strobe,
        output reg_write_word,
        input reg_read_word
    );
endinterface
`default_nettype wire

// File: io_sync.sv
`timescale 1ns/1ps
`default_nettype none
module io_sync #(
    parameter int WIDTH = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule // io_sync
`default_nettype wire

// File: hrp_bridge.sv
`timescale 1ns/1ps
`default_nettype none
`include "hrp_regs.svh"
module hrp_bridge
    import hrp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    hrp_if.bridge bus,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [`HRP_ADDR_W-1:0] req_addr_i,
    input wire logic [`HRP_DATA_W-1:0] req_data_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [`HRP_DATA_W-1:0] rsp_data_o
);
    bridge_state_t state;

    // one request per strobe; idle between keeps strobes one cycle wide
    assign req_ready_o = (state == BR_IDLE);
    assign bus.read_strobe = (state == BR_READ); // R3
    assign bus.write_strobe = (state == BR_WRITE); // R4 R16

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin // R1
        if (!rst_n_i) begin
            state <= BR_IDLE;
        end else begin
            unique case (state)
                BR_IDLE: begin
                    if (req_valid_i) begin
                        state <= req_write_i ? BR_WRITE : BR_READ;
                    end
                end
                BR_READ: state <= BR_IDLE;
                BR_WRITE: state <= BR_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus.reg_select <= '0;
            bus.reg_write_word <= '0;
        end else if (req_ready_o && req_valid_i) begin // R2 R6
            bus.reg_select <= req_addr_i;
            bus.reg_write_word <= req_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o <= '0;
        end else begin
            rsp_valid_o <= (state == BR_READ);
            if (state == BR_READ) begin
                rsp_data_o <= bus.reg_read_word;
            end
        end
    end
endmodule // hrp_bridge
`default_nettype wire

// File: hrp_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "hrp_regs.svh"
module hrp_props (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [`HRP_ADDR_W-1:0] reg_select,
    input wire logic read_strobe,
    input wire logic write_strobe,
    input wire logic [`HRP_DATA_W-1:0] reg_write_word,
    input wire logic [`HRP_DATA_W-1:0] reg_read_word
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_rd_pulse;
        read_strobe |=> !read_strobe;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("read pulse too long");
    property p_wr_pulse;
        write_strobe |=> !write_strobe;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write pulse too long");
    property p_excl;
        !(read_strobe && write_strobe);
    endproperty
    a_excl: assert property (p_excl)
        else $error("read and write together");
    property p_sel_hold;
        read_strobe |=> $stable(reg_select);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("select moved after read");
    property p_word_hold;
        write_strobe |=> $stable(reg_write_word);
    endproperty
    a_word_hold: assert property (p_word_hold)
        else $error("write word moved");
    property p_capture;
        write_strobe && reg_select inside {`HRP_REG_OUT, `HRP_REG_OEN,
                                           `HRP_REG_SCRATCH}
            |=> reg_read_word == $past(reg_write_word);
    endproperty
    a_capture: assert property (p_capture)
        else $error("write not captured");
    property p_unmapped;
        reg_select > `HRP_REG_RDCNT |-> reg_read_word == `HRP_UNMAPPED;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read word wrong");
    // scratch only moves on its own write
    property p_mux_hold;
        reg_select == `HRP_REG_SCRATCH && $stable(reg_select)
            && !$past(write_strobe) |-> $stable(reg_read_word);
    endproperty
    a_mux_hold: assert property (p_mux_hold)
        else $error("read word moved without write");
endmodule // hrp_props
`default_nettype wire

// File: host_register_port_with_io_ring_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "hrp_regs.svh"
`define CHK(g, e) check_eq(g, e)
module host_register_port_with_io_ring_bench;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [4:0] req_addr = 5'h00;
    logic [15:0] req_data = 16'h0000;
    logic [15:0] io_in = 16'h0000;
    logic req_ready, rsp_valid;
    logic [15:0] rsp_data, io_out, io_oen_n, q, d, cnt;
    logic [15:0] shadow [4];
    logic [4:0] a;
    int seed = 70146;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    hrp_if link();
    hrp_core u_hrp_core (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .bus(link.core), .io_cell_inputs_i(io_in),
        .io_cell_outputs_o(io_out), .io_output_enable_n_o(io_oen_n));
    hrp_bridge u_hrp_bridge (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .bus(link.bridge), .req_valid_i(req_valid),
        .req_write_i(req_write), .req_addr_i(req_addr),
        .req_data_i(req_data), .req_ready_o(req_ready),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data));
    hrp_props props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .reg_select(link.reg_select), .read_strobe(link.read_strobe),
        .write_strobe(link.write_strobe),
        .reg_write_word(link.reg_write_word),
        .reg_read_word(link.reg_read_word));
    ////////////////////////////////////////
    initial begin
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            complete_run;
        end
    end
    task automatic complete_run;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check_eq(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("ERROR %0t: got %h want %h", $time, g, e);
        end
    endtask
    function automatic logic [15:0] expect_word(input logic [4:0] x);
        case (x)
            5'h00, 5'h01, 5'h03: return shadow[x[1:0]];
            5'h02: return io_in;
            5'h04: return cnt;
            default: return `HRP_UNMAPPED;
        endcase
    endfunction
    // held valid until ready seen, so nothing is dropped while refused
    task automatic xfer(input logic w, input logic [4:0] x,
                        input logic [15:0] v, output logic [15:0] r);
        int n;
        @(negedge ref_clk_i);
        req_valid = 1'b1;
        req_write = w;
        req_addr = x;
        req_data = v;
        n = 0;
        while (req_ready !== 1'b1 && n < 8) begin
            @(negedge ref_clk_i);
            n++;
        end
        `CHK(16'(req_ready), 16'h0001);
        @(negedge ref_clk_i);
        req_valid = 1'b0;
        n = 0;
        while (!w && rsp_valid !== 1'b1 && n < 8) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (!w) `CHK(16'(rsp_valid), 16'h0001);
        r = rsp_data;
    endtask
    task automatic do_reset;
        rst_n_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        shadow = '{16'h0000, 16'hffff, 16'h0000, 16'h0000};
        cnt = 16'h0000;
        `CHK(io_out, 16'h0000);
        `CHK(io_oen_n, 16'hffff);
        $display("reset test done");
    endtask
    initial begin
        do_reset;
        for (int i = 0; i < 80; i++) begin
            a = 5'($random(seed));
            if (a[4]) a = {2'b00, a[2:0]};
            d = 16'($random(seed));
            io_in = 16'($random(seed));
            repeat (3) @(negedge ref_clk_i);
            if (d[0]) begin
                xfer(1'b1, a, d, q);
                if (a inside {5'h00, 5'h01, 5'h03}) shadow[a[1:0]] = d;
                @(negedge ref_clk_i);
                `CHK(io_out, shadow[0]);
                `CHK(io_oen_n, shadow[1]);
            end else begin
                xfer(1'b0, a, 16'h0000, q);
                `CHK(q, expect_word(a));
                if (a == 5'h02) cnt++;
            end
        end
        $display("random test done");
        xfer(1'b0, 5'h1f, 16'h0000, q);
        `CHK(q, `HRP_UNMAPPED);
        xfer(1'b0, 5'h04, 16'h0000, q);
        `CHK(q, cnt);
        $display("corner test done");
        do_reset;
        xfer(1'b0, 5'h03, 16'h0000, q);
        `CHK(q, 16'h0000);
        complete_run;
    end
endmodule // host_register_port_with_io_ring_bench
`default_nettype wire
